// File: hdl/clk_src_pkg.sv
// Purpose: Shared constants, types and decode helpers for the system clock source selector.
// Assumes: One 100 MHz logic clock; oscillators are seen as one-cycle tick enables.
// Notes:   Register map and status layout are used by the block and by its bench.
package clk_src_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_STATUS   = 4'h1;
	localparam logic [3:0] REG_INT_STAT = 4'h2;
	localparam logic [3:0] REG_INT_MASK = 4'h3;

	localparam int CTRL_SCS_LSB = 0;
	localparam int CTRL_IFS_LSB = 2;
	localparam logic [1:0] SCS_RESET = 2'h0;
	localparam logic [3:0] IFS_RESET = 4'h7;
	localparam logic [1:0] SCS_PRIMARY   = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;
	localparam int SCS_INTERNAL_BIT = 1;

	localparam int ST_SRC_LSB  = 0;
	localparam int ST_OST_DONE = 2;
	localparam int ST_HF_READY = 3;
	localparam int ST_PRI_RUN  = 4;
	localparam int ST_SEC_RUN  = 5;
	localparam int ST_FAIL     = 6;
	localparam int ST_CPU_RUN  = 7;

	localparam int INT_W      = 3;
	localparam int INT_FAIL   = 0;
	localparam int INT_OST    = 1;
	localparam int INT_SWITCH = 2;

	typedef enum logic [2:0] {
		LOW_GAIN_CRYSTAL_MODE  = 3'h0,
		MID_GAIN_CRYSTAL_MODE  = 3'h1,
		HIGH_GAIN_CRYSTAL_MODE = 3'h2,
		EXT_RC_MODE            = 3'h3,
		INTERNAL_OSC_MODE      = 3'h4,
		EXT_CLK_LOW_POWER      = 3'h5,
		EXT_CLK_MID_POWER      = 3'h6,
		EXT_CLK_HIGH_POWER     = 3'h7
	} osc_mode_t;

	typedef enum logic [1:0] {
		SRC_HOLD      = 2'h0,
		SRC_PRIMARY   = 2'h1,
		SRC_SECONDARY = 2'h2,
		SRC_INTERNAL  = 2'h3
	} src_t;

	typedef enum logic [1:0] {
		GAIN_OFF  = 2'h0,
		GAIN_LOW  = 2'h1,
		GAIN_MID  = 2'h2,
		GAIN_HIGH = 2'h3
	} gain_t;

	localparam longint CLK_HZ        = 100_000_000;
	localparam longint HF_HZ         = 16_000_000;
	localparam longint LF_HZ         = 31_000;
	localparam int     CLK_PERIOD_NS = 10;
	localparam int     HF_START_NS   = 5000;
	localparam int     HF_DIV        = int'(CLK_HZ / HF_HZ);
	localparam int     LF_DIV        = int'(CLK_HZ / LF_HZ);
	localparam int     HF_START_CYC  = (HF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int     STARTUP_DIV   = 8;
	localparam int     OST_CYCLES    = 1024;
	localparam int     FAIL_LF_TICKS = 4;
	localparam int     POST_W        = 9;
	localparam logic [3:0] SHIFT_LF  = 4'hF;

	function automatic logic is_crystal(input osc_mode_t m);
		return (m == LOW_GAIN_CRYSTAL_MODE) || (m == MID_GAIN_CRYSTAL_MODE) ||
			(m == HIGH_GAIN_CRYSTAL_MODE);
	endfunction

	function automatic logic is_external(input osc_mode_t m);
		return m != INTERNAL_OSC_MODE;
	endfunction

	// Postscaler shift for each internal frequency code; SHIFT_LF picks the 31 kHz source.
	function automatic logic [3:0] ifs_shift(input logic [3:0] code);
		unique case (code)
			4'hF: return 4'h0;
			4'hE: return 4'h1;
			4'hD: return 4'h2;
			4'hC: return 4'h3;
			4'hB: return 4'h4;
			4'hA, 4'h7: return 4'h5;
			4'h9, 4'h6: return 4'h6;
			4'h8, 4'h5: return 4'h7;
			4'h4: return 4'h8;
			4'h3, 4'h2: return 4'h9;
			4'h1, 4'h0: return SHIFT_LF;
		endcase
	endfunction

endpackage

// File: hdl/edge_monitor.sv
// Purpose: Synchronise an oscillator pin, give one pulse per rising edge, and flag activity.
// Assumes: Pin toggles well below half of clk; the activity window counts slow ticks.
// Notes:   Running drops once LIMIT slow ticks pass without an edge.
module edge_monitor #(
	parameter int LIMIT = 4
) (
	input  wire logic clk,        // Logic clock.
	input  wire logic rst_n,      // Synchronous reset, active low.
	input  wire logic pin,        // Asynchronous oscillator pin.
	input  wire logic lf_tick,    // Slow timebase enable.
	output logic      edge_pulse, // One cycle per rising pin edge.
	output logic      running     // Edge seen inside the window.
);
	localparam int CW = $clog2(LIMIT + 1);

	logic          sync_a;
	logic          sync_b;
	logic          last;
	logic [CW-1:0] idle;
	logic [CW-1:0] next_idle;

	assign edge_pulse = sync_b && !last;
	assign running    = idle != CW'(LIMIT);

	always_comb begin
		next_idle = idle;
		if (edge_pulse) begin
			next_idle = '0;
		end else if (lf_tick && running) begin
			next_idle = idle + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last   <= 1'b0;
			idle   <= CW'(LIMIT);
		end else begin
			sync_a <= pin;
			sync_b <= sync_a;
			last   <= sync_b;
			idle   <= next_idle;
		end
	end

endmodule // edge_monitor

// File: hdl/system_clock_source_select.sv
// Purpose: Pick, start and supervise the system clock source and hand it out as a tick.
// Assumes: Configuration bits are stable inputs from non-volatile storage on clk.
// Notes:   The system clock is a one-cycle enable, so stopping a source simply freezes state.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
module system_clock_source_select #(
	parameter int HF_DIVIDE    = clk_src_pkg::HF_DIV,
	parameter int LF_DIVIDE    = clk_src_pkg::LF_DIV,
	parameter int START_DIVIDE = clk_src_pkg::STARTUP_DIV,
	parameter int HF_START     = clk_src_pkg::HF_START_CYC,
	parameter int OST_COUNT    = clk_src_pkg::OST_CYCLES,
	parameter int FAIL_TICKS   = clk_src_pkg::FAIL_LF_TICKS
) (
	input  wire logic                       clk,                   // 100 MHz logic clock.
	input  wire logic                       rst_n,                 // Synchronous reset, low.
	input  wire logic [2:0]                 osc_mode_select,       // Config: power-up mode.
	input  wire logic                       failsafe_enable,       // Config: monitor on.
	input  wire logic                       two_speed_enable,      // Config: two-speed start.
	input  wire logic                       clock_output_enable_n, // Config: low routes clock.
	input  wire logic                       power_up_delay_done,   // Power-up delay expired.
	input  wire logic                       wake_pulse,            // Wake from Sleep, one cycle.
	input  wire logic                       primary_osc_in,        // Primary oscillator pin.
	input  wire logic                       secondary_osc_in,      // Secondary oscillator pin.
	input  wire logic                       primary_osc_out_in,    // Second pin, input level.
	output logic                            primary_osc_out_out,   // Second pin, drive level.
	output logic                            primary_osc_out_oe_n,  // Second pin, low drives.
	input  wire logic                       gpio_out_data,         // Port logic drive level.
	input  wire logic                       gpio_oe_n,             // Port logic enable, low.
	output logic                            gpio_in_data,          // Synchronised pin level.
	input  wire logic [clk_src_pkg::ADDR_W-1:0] addr,              // Register address.
	input  wire logic [clk_src_pkg::DATA_W-1:0] wdata,             // Register write data.
	input  wire logic                       wr_en,                 // Write strobe.
	input  wire logic                       rd_en,                 // Read strobe.
	output logic [clk_src_pkg::DATA_W-1:0]  rdata,                 // Read data, next cycle.
	output logic                            sys_clk_tick,          // System clock enable.
	output logic                            cpu_run,               // Execution allowed.
	output logic [1:0]                      amp_gain,              // Crystal amplifier gain.
	output logic [1:0]                      ext_grade,             // External clock grade.
	output logic                            failsafe_flag,         // Clock failure latched.
	output logic [1:0]                      active_source,         // Source now in use.
	output logic                            irq                    // Interrupt, high level.
);
	import clk_src_pkg::*;

	localparam int HF_W   = $clog2(HF_DIVIDE + 1);
	localparam int LF_W   = $clog2(LF_DIVIDE + 1);
	localparam int ST_W   = $clog2(START_DIVIDE + 1);
	localparam int HS_W   = $clog2(HF_START + 1);
	localparam int OST_W  = $clog2(OST_COUNT + 1);

	function automatic logic tick_of(input src_t s, input logic p, input logic q,
			input logic i);
		unique case (s)
			SRC_HOLD:      return 1'b0;
			SRC_PRIMARY:   return p;
			SRC_SECONDARY: return q;
			SRC_INTERNAL:  return i;
		endcase
	endfunction

	osc_mode_t mode;
	assign mode = osc_mode_t'(osc_mode_select);

	logic pri_edge;
	logic pri_run;
	logic sec_edge;
	logic sec_run;
	logic lf_tick;

	edge_monitor #(.LIMIT(FAIL_TICKS)) u_primary (
		.clk        (clk),
		.rst_n      (rst_n),
		.pin        (primary_osc_in),
		.lf_tick    (lf_tick),
		.edge_pulse (pri_edge),
		.running    (pri_run)
	);

	edge_monitor #(.LIMIT(FAIL_TICKS)) u_secondary (
		.clk        (clk),
		.rst_n      (rst_n),
		.pin        (secondary_osc_in),
		.lf_tick    (lf_tick),
		.edge_pulse (sec_edge),
		.running    (sec_run)
	);

	// Internal oscillators and postscaler.
	logic [HF_W-1:0]   hf_cnt;
	logic [HF_W-1:0]   next_hf_cnt;
	logic [LF_W-1:0]   lf_cnt;
	logic [LF_W-1:0]   next_lf_cnt;
	logic [ST_W-1:0]   st_cnt;
	logic [ST_W-1:0]   next_st_cnt;
	logic [HS_W-1:0]   hs_cnt;
	logic [HS_W-1:0]   next_hs_cnt;
	logic [POST_W-1:0] post_cnt;
	logic [POST_W-1:0] next_post_cnt;
	logic [POST_W-1:0] post_mask;
	logic [3:0]        shift;
	logic              hf_ready;
	logic              hf_tick;
	logic              st_tick;
	logic              int_tick;
	logic [1:0]        scs;
	logic [3:0]        ifs;

	assign hf_tick  = hf_cnt == HF_W'(HF_DIVIDE - 1);
	assign lf_tick  = lf_cnt == LF_W'(LF_DIVIDE - 1);
	assign st_tick  = st_cnt == ST_W'(START_DIVIDE - 1);
	assign hf_ready = hs_cnt == HS_W'(HF_START);
	assign shift     = ifs_shift(ifs);
	assign post_mask = POST_W'((10'h001 << shift) - 10'h001);

	always_comb begin
		next_hf_cnt   = hf_tick ? '0 : hf_cnt + 1'b1;
		next_lf_cnt   = lf_tick ? '0 : lf_cnt + 1'b1;
		next_st_cnt   = st_tick ? '0 : st_cnt + 1'b1;
		next_hs_cnt   = hf_ready ? hs_cnt : hs_cnt + 1'b1;
		next_post_cnt = (hf_tick && hf_ready) ? post_cnt + 1'b1 : post_cnt;
		if (shift == SHIFT_LF) begin
			int_tick = lf_tick;
		end else if (hf_ready) begin
			int_tick = hf_tick && ((post_cnt & post_mask) == post_mask);
		end else begin
			int_tick = st_tick;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hf_cnt   <= '0;
			lf_cnt   <= '0;
			st_cnt   <= '0;
			hs_cnt   <= '0;
			post_cnt <= '0;
		end else begin
			hf_cnt   <= next_hf_cnt;
			lf_cnt   <= next_lf_cnt;
			st_cnt   <= next_st_cnt;
			hs_cnt   <= next_hs_cnt;
			post_cnt <= next_post_cnt;
		end
	end

	// Start-up counter, restarted by power-up delay expiry or wake.
	logic [OST_W-1:0] ost_cnt;
	logic [OST_W-1:0] next_ost_cnt;
	logic             ost_done;
	logic             next_ost_done;
	logic             pwr_q;
	logic             ost_ready;
	logic             ost_evt;

	assign ost_ready = ost_done || !is_crystal(mode);

	always_comb begin
		next_ost_cnt  = ost_cnt;
		next_ost_done = ost_done;
		if (wake_pulse || (power_up_delay_done && !pwr_q)) begin
			next_ost_cnt  = '0;
			next_ost_done = 1'b0;
		end else if (!ost_done && pri_edge && is_crystal(mode)) begin
			next_ost_cnt  = ost_cnt + 1'b1;
			next_ost_done = ost_cnt == OST_W'(OST_COUNT - 1);
		end
		ost_evt = next_ost_done && !ost_done;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ost_cnt  <= '0;
			ost_done <= 1'b0;
			pwr_q    <= 1'b0;
		end else begin
			ost_cnt  <= next_ost_cnt;
			ost_done <= next_ost_done;
			pwr_q    <= power_up_delay_done;
		end
	end

	// Source selection and failure monitor.
	src_t cur_src;
	src_t next_src;
	src_t wanted;
	logic next_fail;
	logic fail_det;
	logic fail_evt;
	logic switch_evt;
	logic wr_ctrl;
	logic next_tick;

	assign wr_ctrl = wr_en && (addr == REG_CTRL);
	assign fail_det = failsafe_enable && is_external(mode) && !pri_run;
	assign fail_evt = fail_det && !failsafe_flag;

	always_comb begin
		// Set wins over the software clear.
		next_fail = fail_det ? 1'b1 : (wr_ctrl ? 1'b0 : failsafe_flag);
		if (failsafe_flag) begin
			wanted = SRC_INTERNAL;
		end else if (scs[SCS_INTERNAL_BIT]) begin
			wanted = SRC_INTERNAL;
		end else if (scs == SCS_SECONDARY) begin
			wanted = sec_run ? SRC_SECONDARY : cur_src;
		end else if (mode == INTERNAL_OSC_MODE) begin
			wanted = SRC_INTERNAL;
		end else if (ost_ready) begin
			wanted = SRC_PRIMARY;
		end else if (two_speed_enable || failsafe_enable) begin
			wanted = SRC_INTERNAL;
		end else begin
			wanted = SRC_HOLD;
		end
		next_src = cur_src;
		if (wanted != cur_src) begin
			if (wanted == SRC_HOLD || tick_of(wanted, pri_edge, sec_edge, int_tick)) begin
				next_src = wanted;
			end
		end
		switch_evt = next_src != cur_src;
		next_tick  = tick_of(cur_src, pri_edge, sec_edge, int_tick);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_src       <= SRC_HOLD;
			failsafe_flag <= 1'b0;
			sys_clk_tick  <= 1'b0;
			cpu_run       <= 1'b0;
		end else begin
			cur_src       <= next_src;
			failsafe_flag <= next_fail;
			sys_clk_tick  <= next_tick;
			cpu_run       <= next_src != SRC_HOLD;
		end
	end

	assign active_source = cur_src;

	// Register file and interrupt.
	logic [INT_W-1:0]  int_stat;
	logic [INT_W-1:0]  next_int_stat;
	logic [INT_W-1:0]  int_mask;
	logic [INT_W-1:0]  next_int_mask;
	logic [INT_W-1:0]  events;
	logic [1:0]        next_scs;
	logic [3:0]        next_ifs;
	logic [DATA_W-1:0] status;
	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		events             = '0;
		events[INT_FAIL]   = fail_evt;
		events[INT_OST]    = ost_evt;
		events[INT_SWITCH] = switch_evt;
		next_scs      = wr_ctrl ? wdata[CTRL_SCS_LSB +: 2] : scs;
		next_ifs      = wr_ctrl ? wdata[CTRL_IFS_LSB +: 4] : ifs;
		next_int_mask = (wr_en && addr == REG_INT_MASK) ? wdata[INT_W-1:0] : int_mask;
		next_int_stat = int_stat;
		if (wr_en && addr == REG_INT_STAT) begin
			next_int_stat = int_stat & ~wdata[INT_W-1:0];
		end
		next_int_stat = next_int_stat | events;
		status                       = '0;
		status[ST_SRC_LSB +: 2]      = cur_src;
		status[ST_OST_DONE]          = ost_done;
		status[ST_HF_READY]          = hf_ready;
		status[ST_PRI_RUN]           = pri_run;
		status[ST_SEC_RUN]           = sec_run;
		status[ST_FAIL]              = failsafe_flag;
		status[ST_CPU_RUN]           = cpu_run;
		next_rdata = '0;
		if (rd_en) begin
			unique case (addr)
				REG_CTRL: begin
					next_rdata[CTRL_SCS_LSB +: 2] = scs;
					next_rdata[CTRL_IFS_LSB +: 4] = ifs;
				end
				REG_STATUS:   next_rdata = status;
				REG_INT_STAT: next_rdata[INT_W-1:0] = int_stat;
				REG_INT_MASK: next_rdata[INT_W-1:0] = int_mask;
				default:      next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scs      <= SCS_RESET;
			ifs      <= IFS_RESET;
			int_stat <= '0;
			int_mask <= '0;
			rdata    <= '0;
			irq      <= 1'b0;
		end else begin
			scs      <= next_scs;
			ifs      <= next_ifs;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			rdata    <= next_rdata;
			irq      <= |(next_int_stat & next_int_mask);
		end
	end

	// Pins and analogue controls.
	logic       gp_a;
	logic       clock_output_pin;
	logic       next_clock_output_pin;
	logic       next_pin_out;
	logic       next_pin_oe_n;
	logic [1:0] next_gain;
	logic [1:0] next_grade;

	always_comb begin
		next_clock_output_pin = sys_clk_tick ? !clock_output_pin : clock_output_pin;
		unique case (mode)
			LOW_GAIN_CRYSTAL_MODE:  next_gain = GAIN_LOW;
			// Mid gain up to 4 MHz.
			MID_GAIN_CRYSTAL_MODE:  next_gain = GAIN_MID;
			HIGH_GAIN_CRYSTAL_MODE: next_gain = GAIN_HIGH;
			default:                next_gain = GAIN_OFF;
		endcase
		unique case (mode)
			EXT_CLK_LOW_POWER:  next_grade = GAIN_LOW;
			EXT_CLK_MID_POWER:  next_grade = GAIN_MID;
			EXT_CLK_HIGH_POWER: next_grade = GAIN_HIGH;
			default:            next_grade = GAIN_OFF;
		endcase
		if (is_crystal(mode)) begin
			next_pin_out  = 1'b0;
			next_pin_oe_n = 1'b1;
		end else if (!clock_output_enable_n) begin
			next_pin_out  = next_clock_output_pin;
			next_pin_oe_n = 1'b0;
		end else begin
			next_pin_out  = gpio_out_data;
			next_pin_oe_n = gpio_oe_n;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gp_a                 <= 1'b0;
			gpio_in_data         <= 1'b0;
			clock_output_pin               <= 1'b0;
			primary_osc_out_out  <= 1'b0;
			primary_osc_out_oe_n <= 1'b1;
			amp_gain             <= GAIN_OFF;
			ext_grade            <= GAIN_OFF;
		end else begin
			gp_a                 <= primary_osc_out_in;
			gpio_in_data         <= gp_a;
			clock_output_pin               <= next_clock_output_pin;
			primary_osc_out_out  <= next_pin_out;
			primary_osc_out_oe_n <= next_pin_oe_n;
			amp_gain             <= next_gain;
			ext_grade            <= next_grade;
		end
	end

endmodule // system_clock_source_select

// File: bench/osc_partner.sv
// Purpose: Behavioural primary source and secondary crystal for the selector bench.
// Assumes: Pins are asynchronous to the logic clock; half periods are in ns.
// Notes:   A stopped source holds its last level, as a halted oscillator does.
module osc_partner (
	input  wire logic       run_pri, // Primary running.
	input  wire logic       run_sec, // Secondary running.
	input  wire logic [7:0] half_ns, // Primary half period.
	output logic            pri_pin, // Primary input pin.
	output logic            sec_pin  // Secondary pin.
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		pri_pin = 1'b0;
		forever begin
			#(half_ns);
			if (run_pri) begin
				pri_pin = ~pri_pin;
			end
		end
	end
	initial begin
		sec_pin = 1'b0;
		forever begin
			#(half_ns + 5);
			if (run_sec) begin
				sec_pin = ~sec_pin;
			end
		end
	end
endmodule // osc_partner

// File: bench/clk_src_asserts.sv
// Purpose: Port-level checks for the clock source selector.
// Assumes: Configuration inputs change only around reset, except failsafe_enable, which the bench also sets while running.
// Notes:   Wait windows suit the bench's short counts and fast internal codes.
module clk_src_asserts
	import clk_src_pkg::*;
(
	input wire logic       clk,                  // Clock.
	input wire logic       rst_n,                // Reset.
	input wire logic [2:0] osc_mode_select,      // Mode.
	input wire logic       failsafe_enable,      // Monitor on.
	input wire logic       two_speed_enable,     // Two-speed on.
	input wire logic [3:0] addr,                 // Address.
	input wire logic [7:0] wdata,                // Write data.
	input wire logic       wr_en,                // Write strobe.
	input wire logic       cpu_run,              // Execution.
	input wire logic [1:0] amp_gain,             // Gain.
	input wire logic [1:0] ext_grade,            // Grade.
	input wire logic       failsafe_flag,        // Failure.
	input wire logic [1:0] active_source,        // Source.
	input wire logic       primary_osc_out_oe_n  // Pin enable.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic xtal;
	assign xtal = osc_mode_select < 3'h3;
	grade_decode_a: assert property ($past(rst_n) && $stable(osc_mode_select) |->
		ext_grade == (osc_mode_select > 3'h4 ? osc_mode_select[1:0] : 2'h0))
		else $error("external clock grade wrong");
	gain_decode_a: assert property ($past(rst_n) && $stable(osc_mode_select) |->
		amp_gain == (xtal ? osc_mode_select[1:0] + 2'h1 : 2'h0))
		else $error("amplifier gain wrong");
	crystal_pin_a: assert property ($past(rst_n) && $stable(osc_mode_select) && xtal |->
		primary_osc_out_oe_n) else $error("second pin driven in crystal mode");
	ext_start_a: assert property ($rose(rst_n) && osc_mode_select > 3'h4 && !failsafe_enable
		|-> ##[1:40] active_source == SRC_PRIMARY) else $error("external clock start late");
	xtal_hold_a: assert property ($rose(rst_n) && xtal && !two_speed_enable &&
		!failsafe_enable |-> (!cpu_run) [*8]) else $error("crystal start not held");
	fail_fallback_a: assert property ($rose(failsafe_flag) |->
		##[0:700] active_source == SRC_INTERNAL) else $error("no fallback to internal");
	flag_sticky_a: assert property (failsafe_flag && !(wr_en && addr == REG_CTRL) |=>
		failsafe_flag) else $error("failure flag dropped");
	sw_internal_a: assert property (wr_en && addr == REG_CTRL && wdata[SCS_INTERNAL_BIT]
		|-> ##[1:700] active_source == SRC_INTERNAL) else $error("internal select ignored");
	cover property (active_source == SRC_SECONDARY);
	cover property ($rose(failsafe_flag));
	cover property ($rose(cpu_run) && two_speed_enable);
endmodule // clk_src_asserts
bind system_clock_source_select clk_src_asserts u_chk (.clk, .rst_n, .osc_mode_select,
	.failsafe_enable, .two_speed_enable, .addr, .wdata, .wr_en, .cpu_run, .amp_gain,
	.ext_grade, .failsafe_flag, .active_source, .primary_osc_out_oe_n);

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the clock source selector.
// Assumes: Short counts: slow divide 8, failure window 2, start-up count 8.
// Notes:   Reads are queued by the driver and compared by a monitor.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import clk_src_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, failsafe_enable = 1'b0, two_speed_enable = 1'b0;
	logic        clock_output_enable_n = 1'b1, gpio_out_data = 1'b0, gpio_oe_n = 1'b1;
	logic        wr_en = 1'b0, rd_en = 1'b0, rd_d = 1'b0, run_pri = 1'b1, run_sec = 1'b1;
	logic        wake_pulse = 1'b0;
	logic        primary_osc_in, secondary_osc_in, primary_osc_out_out, primary_osc_out_oe_n;
	logic        gpio_in_data, sys_clk_tick, cpu_run, failsafe_flag, irq, pin2;
	logic [1:0]  amp_gain, ext_grade, active_source;
	logic [2:0]  osc_mode_select = 3'h7;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00, half_ns = 8'h1E, rdata;
	logic [15:0] note, q[$];
	int          num_errors = 0, checks_done = 0, ticks = 0, seed = 32'h7fa5272c;
	// A released second pin is pulled high.
	assign pin2 = primary_osc_out_oe_n ? 1'b1 : primary_osc_out_out;
	system_clock_source_select #(.LF_DIVIDE(8), .FAIL_TICKS(2), .OST_COUNT(8), .HF_START(4)) u_dut (
		.clk, .rst_n, .osc_mode_select, .failsafe_enable, .two_speed_enable,
		.clock_output_enable_n, .power_up_delay_done(1'b1), .wake_pulse,
		.primary_osc_in, .secondary_osc_in, .primary_osc_out_in(pin2), .primary_osc_out_out,
		.primary_osc_out_oe_n, .gpio_out_data, .gpio_oe_n, .gpio_in_data, .addr, .wdata,
		.wr_en, .rd_en, .rdata, .sys_clk_tick, .cpu_run, .amp_gain, .ext_grade,
		.failsafe_flag, .active_source, .irq);
	osc_partner u_osc (.run_pri, .run_sec, .half_ns, .pri_pin(primary_osc_in),
		.sec_pin(secondary_osc_in));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		ticks <= ticks + int'(sys_clk_tick === 1'b1);
		if (rd_d) begin
			note = q.pop_front();
			cmp("rdata", {8'h00, note[15:8]}, {8'h00, rdata & note[7:0]});
		end
		rd_d = rd_en;
	end
	task automatic cmp(input string nm, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, mask);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		q.push_back({exp, mask});
		@(posedge clk);
		rd_en <= 1'b0;
	endtask
	task automatic restart(input logic [2:0] m, input logic ts);
		@(posedge clk);
		rst_n <= 1'b0;
		osc_mode_select <= m;
		two_speed_enable <= ts;
		failsafe_enable <= 1'b0;
		half_ns <= 8'd20 + 8'({$random(seed)} % 11);
		clock_output_enable_n <= 1'($random(seed));
		gpio_oe_n <= 1'($random(seed));
		gpio_out_data <= 1'($random(seed));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic wait_src(input logic [1:0] s);
		int n;
		n = 0;
		while (active_source !== s && n < 1000) begin
			@(posedge clk);
			n++;
		end
		cmp("active_source", {14'h0, s}, {14'h0, active_source});
		if (active_source !== s) complete_run();
	endtask
	// The first two waits absorb a handover; the last one is a full period.
	task automatic gap(input logic [15:0] exp);
		int t0, n;
		for (int k = 0; k < 3; k++) begin
			t0 = ticks;
			n = 0;
			while (ticks == t0 && n < 2000) begin
				@(posedge clk);
				n++;
			end
		end
		cmp("tick_gap", exp, 16'(n));
		if (n == 2000) complete_run();
	endtask
	task automatic complete_run();
		repeat (3) @(posedge clk);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		int t0;
		logic [3:0] code;
		for (int m = 0; m < 8; m++) begin
			restart(3'(m), 1'b0);
			repeat (22) @(posedge clk);
			@(negedge clk);
			t0 = int'(m < 3 || (clock_output_enable_n && gpio_oe_n));
			cmp("amp_gain", 16'(m < 3 ? m + 1 : 0), {14'h0, amp_gain});
			cmp("ext_grade", 16'(m > 4 ? m - 4 : 0), {14'h0, ext_grade});
			cmp("oe_n", 16'(t0), {15'h0, primary_osc_out_oe_n});
			// A pin carrying the clock output toggles freely, so only fixed levels are checked.
			if (m < 3 || clock_output_enable_n) begin
				cmp("gpio_in", {15'h0, t0 != 0 || gpio_out_data}, {15'h0, gpio_in_data});
			end
			rd(REG_STATUS, (m < 3 || m == 4) ? 8'h00 : 8'h81, 8'h83);
			rd(REG_CTRL, 8'h1C, 8'hFF);
			repeat (400) @(posedge clk);
			rd(REG_STATUS, (m == 4) ? 8'h8B : 8'h89, 8'h8B);
		end
		wr(4'h9, 8'hFF);
		rd(4'h9, 8'h00, 8'hFF);
		rd(REG_CTRL, 8'h1C, 8'hFF);
		run_pri <= 1'b0;
		restart(3'h2, 1'b1);
		repeat (400) @(posedge clk);
		rd(REG_STATUS, 8'h83, 8'h83);
		run_pri <= 1'b1;
		wait_src(SRC_PRIMARY);
		rd(REG_INT_STAT, 8'h02, 8'h02);
		cmp("irq", 16'h0, {15'h0, irq});
		wr(REG_INT_MASK, 8'h02);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp("irq", 16'h1, {15'h0, irq});
		wr(REG_INT_STAT, 8'h07);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp("irq", 16'h0, {15'h0, irq});
		// Wake restarts the start-up count, which must finish again and raise its event.
		@(posedge clk);
		wake_pulse <= 1'b1;
		@(posedge clk);
		wake_pulse <= 1'b0;
		rd(REG_STATUS, 8'h00, 8'h04);
		repeat (100) @(posedge clk);
		rd(REG_INT_STAT, 8'h02, 8'h02);
		cmp("irq", 16'h1, {15'h0, irq});
		restart(3'h7, 1'b0);
		wait_src(SRC_PRIMARY);
		wr(REG_CTRL, 8'h24);
		run_pri <= 1'b0;
		repeat (20) @(posedge clk);
		t0 = ticks;
		repeat (100) @(posedge clk);
		cmp("frozen_ticks", 16'(t0), 16'(ticks));
		rd(REG_CTRL, 8'h24, 8'hFF);
		run_pri <= 1'b1;
		repeat (50) @(posedge clk);
		cmp("resumed", 16'h1, 16'(ticks > t0));
		failsafe_enable <= 1'b1;
		repeat (10) @(posedge clk);
		rd(REG_STATUS, 8'h81, 8'hC3);
		run_pri <= 1'b0;
		wait_src(SRC_INTERNAL);
		rd(REG_STATUS, 8'hC3, 8'hC3);
		rd(REG_INT_STAT, 8'h01, 8'h01);
		run_pri <= 1'b1;
		repeat (30) @(posedge clk);
		wr(REG_CTRL, 8'h24);
		wait_src(SRC_PRIMARY);
		rd(REG_STATUS, 8'h81, 8'hC3);
		for (int i = 0; i < 6; i++) begin
			code = (i == 0) ? 4'h0 : 4'h9 + 4'({$random(seed)} % 7);
			wr(REG_CTRL, {2'b00, code, 2'b10});
			rd(REG_CTRL, {2'b00, code, 2'b10}, 8'hFF);
			wait_src(SRC_INTERNAL);
			gap((code == 4'h0) ? 16'd8 : 16'(6 << (15 - code)));
		end
		wr(REG_CTRL, 8'h1D);
		wait_src(SRC_SECONDARY);
		wr(REG_CTRL, 8'h1C);
		wait_src(SRC_PRIMARY);
		complete_run();
	end
endmodule // tb_top
